/* File: core/swp_top.v */
// Sleep, wake-up delay and port A pin control, AXI4-Lite register slave.
// Assumes pins arrive asynchronously and a slow oscillator enable pulse.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`include "swp_defines.vh"

module swp_top #(
	parameter WIDTH = 8,
	parameter RST_PIN = 5,
	parameter RST_PIN_OPEN_DRAIN = 0
) (
	input wire clock_i,
	input wire resetn_i,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port A pads
	input wire [WIDTH-1:0] pad_i,
	output reg [WIDTH-1:0] pad_o,
	output reg [WIDTH-1:0] pad_oe_o,
	output reg [WIDTH-1:0] pull_up_o,
	output reg [WIDTH-1:0] pull_down_o,
	// Wake events and clocking
	input wire slow_tick_i,
	input wire timer_wake_i,
	input wire cmp_wake_i,
	input wire soft_reset_cause_i,
	output reg fast_osc_en_o,
	output reg slow_osc_en_o,
	output reg prog_mem_on_o,
	output reg sys_clk_en_o,
	output reg cpu_restart_o,
	output reg sram_clear_o,
	output reg [WIDTH-1:0] irq_pin_edge_o
);
	localparam ST_RUN = 2'd0;
	localparam ST_LIGHT = 2'd1;
	localparam ST_DEEP = 2'd2;
	localparam ST_WAKE = 2'd3;

	reg [1:0] state_q;
	reg [7:0] ctrl_q;
	reg [WIDTH-1:0] dir_q;
	reg [WIDTH-1:0] out_q;
	reg [WIDTH-1:0] puen_q;
	reg [WIDTH-1:0] pden_q;
	reg [WIDTH-1:0] wakeen_q;
	reg [WIDTH-1:0] sync1_q;
	reg [WIDTH-1:0] sync2_q;
	reg [WIDTH-1:0] prev_q;
	reg [7:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_have_q;
	reg wake_start_q;
	wire wake_done;
	wire [WIDTH-1:0] toggle;
	wire pin_wake;
	wire fast_sel;
	wire [11:0] limit;
	wire do_write;
	wire [WIDTH-1:0] port_read;

	// ==========================================
	// Pin synchroniser and toggle detection
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_q <= {WIDTH{1'b0}};
			sync2_q <= {WIDTH{1'b0}};
			prev_q <= {WIDTH{1'b0}};
		end else begin
			sync1_q <= pad_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Only enabled digital inputs may wake
	assign toggle = (sync2_q ^ prev_q) & wakeen_q & ~dir_q;
	assign pin_wake = |toggle;

	// Fast wake honoured only with slow boot-up set
	assign fast_sel = ctrl_q[`SWP_CTRL_FASTWAKE] &
		ctrl_q[`SWP_CTRL_SLOWBOOT];
	assign limit = fast_sel ? `SWP_WAKE_FAST : `SWP_WAKE_NORMAL;

	// ==========================================
	// Pad drive, pulls and port read per bit
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			wire od;
			assign od = (RST_PIN_OPEN_DRAIN != 0) && (g == RST_PIN);
			always @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					pad_o[g] <= 1'b0;
					pad_oe_o[g] <= 1'b0;
					pull_up_o[g] <= 1'b0;
					pull_down_o[g] <= 1'b0;
				end else begin
					// Open drain only ever drives low
					pad_o[g] <= od ? 1'b0 : out_q[g];
					pad_oe_o[g] <= dir_q[g] & (~od | ~out_q[g]);
					// Outputs carry no pulls at all
					pull_up_o[g] <= ~dir_q[g] & puen_q[g];
					pull_down_o[g] <= ~dir_q[g] & pden_q[g] &
						~puen_q[g];
				end
			end
			assign port_read[g] = dir_q[g] ? out_q[g] : sync2_q[g];
		end
	endgenerate

	// ==========================================
	// AXI write channel capture, either order
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_addr_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SWP_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready;
			s_axi_wready <= !w_have_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_q)
				`SWP_OFF_CTRL, `SWP_OFF_CMD, `SWP_OFF_DIR, `SWP_OFF_OUT,
				`SWP_OFF_PUEN, `SWP_OFF_PDEN, `SWP_OFF_WAKEEN,
				`SWP_OFF_STAT, `SWP_OFF_PORTRD: begin
					s_axi_bresp <= `SWP_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `SWP_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Register file; values kept through every sleep state
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= `SWP_CTRL_RST;
			dir_q <= {WIDTH{1'b0}};
			out_q <= {WIDTH{1'b0}};
			puen_q <= {WIDTH{1'b0}};
			pden_q <= {WIDTH{1'b0}};
			wakeen_q <= {WIDTH{1'b0}};
		end else if (do_write && w_strb_q[0]) begin
			case (aw_addr_q)
			`SWP_OFF_CTRL: ctrl_q <= w_data_q[7:0];
			`SWP_OFF_DIR: dir_q <= w_data_q[WIDTH-1:0];
			`SWP_OFF_OUT: out_q <= w_data_q[WIDTH-1:0];
			`SWP_OFF_PUEN: puen_q <= w_data_q[WIDTH-1:0];
			`SWP_OFF_PDEN: pden_q <= w_data_q[WIDTH-1:0];
			`SWP_OFF_WAKEEN: wakeen_q <= w_data_q[WIDTH-1:0];
			default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ==========================================
	// Sleep state machine and clock gating
	wire cmd_wr;
	assign cmd_wr = do_write && w_strb_q[0] && (aw_addr_q == `SWP_OFF_CMD);

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_RUN;
			wake_start_q <= 1'b0;
			fast_osc_en_o <= 1'b1;
			slow_osc_en_o <= 1'b1;
			prog_mem_on_o <= 1'b1;
			sys_clk_en_o <= 1'b1;
			cpu_restart_o <= 1'b1;
			sram_clear_o <= 1'b0;
			irq_pin_edge_o <= {WIDTH{1'b0}};
		end else begin
			wake_start_q <= 1'b0;
			cpu_restart_o <= 1'b0;
			// Only a power-type reset may clear data memory
			sram_clear_o <= 1'b0;
			irq_pin_edge_o <= (sync2_q ^ prev_q) & wakeen_q;
			case (state_q)
			ST_RUN: begin
				if (cmd_wr && w_data_q[`SWP_CMD_RESTART]) begin
					cpu_restart_o <= 1'b1;
				end else if (cmd_wr && w_data_q[`SWP_CMD_DEEP]) begin
					// Comparator disable is left to software
					state_q <= ST_DEEP;
					fast_osc_en_o <= 1'b0;
					slow_osc_en_o <= 1'b0;
					prog_mem_on_o <= 1'b0;
					sys_clk_en_o <= 1'b0;
				end else if (cmd_wr && w_data_q[`SWP_CMD_LIGHT]) begin
					state_q <= ST_LIGHT;
					sys_clk_en_o <= 1'b0;
					prog_mem_on_o <= 1'b0;
				end
			end
			ST_LIGHT: begin
				if (pin_wake || timer_wake_i || cmp_wake_i) begin
					state_q <= ST_WAKE;
					wake_start_q <= 1'b1;
				end
			end
			ST_DEEP: begin
				// Timer and comparator ignored here
				if (pin_wake) begin
					state_q <= ST_WAKE;
					wake_start_q <= 1'b1;
					slow_osc_en_o <= 1'b1;
					fast_osc_en_o <= 1'b1;
				end
			end
			ST_WAKE: begin
				if (wake_done) begin
					// Continue, no restart pulse
					state_q <= ST_RUN;
					sys_clk_en_o <= 1'b1;
					prog_mem_on_o <= 1'b1;
				end
			end
			default: state_q <= ST_RUN;
			endcase
			if (soft_reset_cause_i) begin
				cpu_restart_o <= 1'b1;
			end
		end
	end

	swp_wake_counter u_wake (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.start_i(wake_start_q),
		.slow_tick_i(slow_tick_i),
		.limit_i(limit),
		.done_o(wake_done)
	);

	// ==========================================
	// AXI read channel
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SWP_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SWP_RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				case (s_axi_araddr)
				`SWP_OFF_CTRL: s_axi_rdata[7:0] <= ctrl_q;
				`SWP_OFF_CMD: s_axi_rdata <= 32'h0000_0000;
				`SWP_OFF_STAT: s_axi_rdata[1:0] <= state_q;
				`SWP_OFF_DIR: s_axi_rdata[WIDTH-1:0] <= dir_q;
				`SWP_OFF_OUT: s_axi_rdata[WIDTH-1:0] <= out_q;
				`SWP_OFF_PUEN: s_axi_rdata[WIDTH-1:0] <= puen_q;
				`SWP_OFF_PDEN: s_axi_rdata[WIDTH-1:0] <= pden_q;
				`SWP_OFF_WAKEEN: s_axi_rdata[WIDTH-1:0] <= wakeen_q;
				`SWP_OFF_PORTRD: s_axi_rdata[WIDTH-1:0] <= port_read;
				default: s_axi_rresp <= `SWP_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: core/swp_defines.vh */
// Shared constants for the sleep / wake-up / port A controller.
// Assumes inclusion by bare name from the core files and the bench.
`ifndef SWP_DEFINES_VH
`define SWP_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define SWP_OFF_CTRL 8'h00
`define SWP_OFF_CMD 8'h04
`define SWP_OFF_STAT 8'h08
`define SWP_OFF_DIR 8'h0C
`define SWP_OFF_OUT 8'h10
`define SWP_OFF_PUEN 8'h14
`define SWP_OFF_PDEN 8'h18
`define SWP_OFF_WAKEEN 8'h1C
`define SWP_OFF_PORTRD 8'h20

// Control register fields
`define SWP_CTRL_FASTWAKE 5
`define SWP_CTRL_SLOWBOOT 0

// Command register fields (write one to issue)
`define SWP_CMD_DEEP 0
`define SWP_CMD_LIGHT 1
`define SWP_CMD_RESTART 2

// Reset values
`define SWP_CTRL_RST 8'h00
`define SWP_WAKEEN_RST 8'h00

// Wake-up delays in slow oscillator periods
`define SWP_WAKE_NORMAL 12'd2048
`define SWP_WAKE_FAST 12'd32

// AXI responses
`define SWP_RESP_OKAY 2'b00
`define SWP_RESP_SLVERR 2'b10

`endif

/* File: core/swp_wake_counter.v */
// Wake-up delay counter clocked by the slow oscillator enable tick.
// Assumes slow_tick_i is a one-cycle pulse per slow oscillator period.
`include "swp_defines.vh"

module swp_wake_counter (
	input wire clock_i,
	input wire resetn_i,
	input wire start_i,
	input wire slow_tick_i,
	input wire [11:0] limit_i,
	output reg done_o
);
	reg [11:0] count_q;
	reg run_q;

	// ==========================================
	// Count slow periods from the wake event
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_q <= 12'h000;
			run_q <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				count_q <= 12'h000;
				run_q <= 1'b1;
			end else if (run_q && slow_tick_i) begin
				// Release once the selected count is reached
				if (count_q + 12'd1 >= limit_i) begin
					run_q <= 1'b0;
					done_o <= 1'b1;
				end
				count_q <= count_q + 12'd1;
			end
		end
	end
endmodule

/* File: tb/swp_top_properties.sv */
// Checker on the ports of the sleep and port A controller.
// Assumes a bind onto swp_top and one clock domain.
module swp_top_properties #(
	parameter WIDTH = 8
) (
	input wire clock_i,
	input wire resetn_i,
	input wire slow_tick_i,
	input wire [WIDTH-1:0] pad_o,
	input wire [WIDTH-1:0] pad_oe_o,
	input wire [WIDTH-1:0] pull_up_o,
	input wire [WIDTH-1:0] pull_down_o,
	input wire fast_osc_en_o,
	input wire slow_osc_en_o,
	input wire prog_mem_on_o,
	input wire sys_clk_en_o,
	input wire cpu_restart_o,
	input wire sram_clear_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic [11:0] tick_q;
	// ========
	// Slow ticks while the system clock is gated, saturating
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			tick_q <= 12'h000;
		else if (sys_clk_en_o)
			tick_q <= 12'h000;
		else if (slow_tick_i && tick_q != 12'hFFF)
			tick_q <= tick_q + 12'h001;
	end
	// ========
	// Sleep and wake
	a_deep_all_off: assert property ($fell(fast_osc_en_o) |->
		!slow_osc_en_o && !prog_mem_on_o && !sys_clk_en_o)
		else $error("deep sleep left a clock running");
	a_light_osc_on: assert property ($fell(sys_clk_en_o) && fast_osc_en_o
		|-> slow_osc_en_o && !prog_mem_on_o)
		else $error("light sleep stopped an oscillator");
	a_wake_not_early: assert property ($rose(sys_clk_en_o)
		|-> tick_q >= 12'h020) else $error("resume before 32 ticks");
	a_wake_no_restart: assert property ($rose(sys_clk_en_o)
		|-> !cpu_restart_o) else $error("wake restarted the cpu");
	a_restart_pulse: assert property (cpu_restart_o |=> !cpu_restart_o)
		else $error("restart longer than one cycle");
	a_sram_kept: assert property (!sram_clear_o)
		else $error("sram cleared");
	// ========
	// Pads
	a_low_no_pull: assert property (
		(pad_oe_o & ~pad_o & (pull_up_o | pull_down_o)) == '0)
		else $error("pull left on a low output");
	a_out_no_pull: assert property (
		(pad_oe_o & (pull_up_o | pull_down_o)) == '0)
		else $error("pull on an output");
	a_pull_up_wins: assert property ((pull_up_o & pull_down_o) == '0)
		else $error("both pulls on");
endmodule

bind swp_top swp_top_properties #(.WIDTH(WIDTH)) swp_top_properties_inst (
	.clock_i, .resetn_i, .slow_tick_i, .pad_o, .pad_oe_o, .pull_up_o,
	.pull_down_o, .fast_osc_en_o, .slow_osc_en_o, .prog_mem_on_o,
	.sys_clk_en_o, .cpu_restart_o, .sram_clear_o);

/* File: tb/swp_pins.sv */
// Outside circuitry on the port A pads.
// Assumes ext_en_i marks pins that an outside driver holds.
module swp_pins (
	input wire logic clock_i,
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] pd_i,
	input wire logic [7:0] ext_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flip_q = 8'h55;
	// Floating pins wander, so a stale level never passes
	always @(posedge clock_i) flip_q <= ~flip_q;
	// Chip drive first, then outside driver, then the pulls
	always_comb level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
		| (~oe_i & ~ext_en_i & (pu_i | (~pd_i & flip_q)));
endmodule

/* File: tb/swp_top_bench.sv */
// Self-checking bench for the sleep, wake-up and port A controller.
// Assumes slow ticks on every cycle to shorten the wake delays.
`include "swp_defines.vh"
module swp_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pad_i, pad_o, pad_oe_o;
	logic [7:0] pull_up_o, pull_down_o, irq_pin_edge_o, ext, ext_en;
	logic [31:0] s_axi_wdata, s_axi_rdata, r, e;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic slow_tick_i, timer_wake_i, cmp_wake_i, soft_reset_cause_i;
	logic fast_osc_en_o, slow_osc_en_o, prog_mem_on_o, sys_clk_en_o;
	logic cpu_restart_o, sram_clear_o;
	logic [33:0] q[$];
	int mismatches, n_compared, cyc, n_rs, n_irq, n;
	logic [31:0] ctl[3] = '{32'h0000_0000, 32'h0000_0021, 32'h0000_0020};
	int lim[3] = '{`SWP_WAKE_NORMAL, `SWP_WAKE_FAST, `SWP_WAKE_NORMAL};

	swp_top swp_top_inst (.*);
	swp_pins swp_pins_inst (.clock_i(clock_i), .drv_i(pad_o),
		.oe_i(pad_oe_o), .pu_i(pull_up_o), .pd_i(pull_down_o),
		.ext_i(ext), .ext_en_i(ext_en), .level_o(pad_i));

	// ========
	// Tasks
	task automatic chk(input logic [33:0] g, input logic [33:0] x,
		input string m);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clock_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, `SWP_RESP_OKAY, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] rr,
		input logic [31:0] d);
		@(posedge clock_i);
		q.push_back({rr, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clock_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
	endtask
	// Bounded wait for the system clock to come back
	task automatic wait_run;
		n = 0;
		while (sys_clk_en_o !== 1'b1 && n < 3000) begin
			@(posedge clock_i);
			n++;
		end
	endtask
	task automatic sleep_wake(input logic [31:0] c, input int lo);
		int k, s;
		wr(`SWP_OFF_CTRL, c);
		// Comparator model stays idle before the sleep command
		wr(`SWP_OFF_CMD, 32'h0000_0001);
		repeat (2) @(posedge clock_i);
		chk({fast_osc_en_o, slow_osc_en_o, prog_mem_on_o, sys_clk_en_o},
			4'h0, "deep");
		k = n_irq;
		s = n_rs;
		timer_wake_i <= 1;
		cmp_wake_i <= 1;
		ext[1] <= ~ext[1];
		repeat (40) @(posedge clock_i);
		chk(sys_clk_en_o, 1'b0, "stray wake");
		timer_wake_i <= 0;
		cmp_wake_i <= 0;
		ext[0] <= ~ext[0];
		wait_run();
		chk(n >= lo && n <= lo + 10, 1'b1, "wake time");
		chk(n_irq - k, 1, "pin edges");
		chk(n_rs - s, 0, "restart on wake");
		rd(`SWP_OFF_OUT, 2'b00, {24'h0, r[7:0]});
	endtask

	// ========
	// Clock, timeout and result watcher
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
		if (resetn_i) n_rs += cpu_restart_o;
		if (resetn_i) n_irq += irq_pin_edge_o;
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rresp == 2'b10 ? 32'h0 : s_axi_rdata},
				q.pop_front(), "read");
	end

	// ========
	// Main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		{slow_tick_i, timer_wake_i, cmp_wake_i, soft_reset_cause_i} = 4'h8;
		ext = 8'h00;
		ext_en = 8'hFF;
		resetn_i = 0;
		void'($urandom(26));
		r = $urandom;
		e = $urandom;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1;
		rd(`SWP_OFF_CTRL, 2'b00, 32'h0000_0000);
		rd(`SWP_OFF_WAKEEN, 2'b00, 32'h0000_0000);
		rd(8'h40, `SWP_RESP_SLVERR, 32'h0000_0000);
		// Low nibble out, both pulls asked on every pin
		wr(`SWP_OFF_DIR, 32'h0000_000F);
		wr(`SWP_OFF_OUT, r);
		wr(`SWP_OFF_PUEN, 32'h0000_00FF);
		wr(`SWP_OFF_PDEN, 32'h0000_00FF);
		ext <= e[7:0];
		ext_en <= 8'h30;
		repeat (4) @(posedge clock_i);
		chk({pad_oe_o, pull_up_o, pull_down_o}, {8'h0F, 8'hF0, 8'h00},
			"pulls");
		chk(pad_o & 8'h0F, r[3:0], "drive");
		rd(`SWP_OFF_PORTRD, 2'b00, {24'h0, 2'b11, e[5:4], r[3:0]});
		// Wake pins set up as software must
		ext_en <= 8'hFF;
		wr(`SWP_OFF_DIR, 32'h0000_0000);
		wr(`SWP_OFF_WAKEEN, 32'h0000_0001);
		foreach (ctl[i]) sleep_wake(ctl[i], lim[i]);
		// Light sleep woken by comparator, then by timer
		for (int i = 0; i < 2; i++) begin
			wr(`SWP_OFF_CMD, 32'h0000_0002);
			repeat (2) @(posedge clock_i);
			chk({fast_osc_en_o, slow_osc_en_o, prog_mem_on_o, sys_clk_en_o},
				4'hC, "light");
			{timer_wake_i, cmp_wake_i} <= 2'b01 << i;
			@(posedge clock_i);
			{timer_wake_i, cmp_wake_i} <= 2'b00;
			wait_run();
			chk(sys_clk_en_o, 1'b1, "light wake");
		end
		n = n_rs;
		wr(`SWP_OFF_CMD, 32'h0000_0004);
		soft_reset_cause_i <= 1;
		@(posedge clock_i);
		soft_reset_cause_i <= 0;
		repeat (3) @(posedge clock_i);
		chk(n_rs - n, 2, "restarts");
		// Second reset in mid-run brings defaults back
		resetn_i <= 0;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1;
		rd(`SWP_OFF_CTRL, 2'b00, 32'h0000_0000);
		repeat (4) @(posedge clock_i);
		summarize();
	end
endmodule
